// *** design/gom_level_mux.sv ***
`timescale 1ns/10ps
module gom_level_mux
    import gom_pkg::*;
(
    input wire gom_ctl_s ctl_i,
    input wire gom_rx_s [RX_PORTS-1:0] rx_i,
    input wire logic [RX_PORTS-1:0] rx_en_i,
    input wire gom_tx_s [TX_PORTS-1:0] tx_i,
    input wire logic frame_sync_pulse_i,
    output logic [RX_PORTS-1:0] lock_vec_o,
    output logic [RX_PORTS-1:0] pass_vec_o,
    output logic level_o
);

    logic [RX_PORTS-1:0] tx_mask;
    gom_rx_s rx_sel;
    gom_tx_s tx_sel;

    genvar g;
    generate
        for (g = 0; g < RX_PORTS; g++)
        begin : g_vec
            assign lock_vec_o[g] = rx_i[g].lock;
            assign pass_vec_o[g] = rx_i[g].pass;
        end
    endgenerate

    assign rx_sel = rx_i[ctl_i.pin3_source_select[1:0]];
    assign tx_sel = tx_i[ctl_i.pin3_source_select[0]];
    assign tx_mask = tx_sel.rx_mask;

    // An empty group of enabled ports gives a low AND, not a vacuous high.
    always_comb
    begin
        level_o = 1'b0;
        if (gom_src_is_rx(ctl_i.pin3_source_select))
        begin
            case (ctl_i.pin3_signal_select)
                SEL_RX_LOCK: level_o = rx_sel.lock;
                SEL_RX_PASS: level_o = rx_sel.pass;
                SEL_RX_FV: level_o = rx_sel.frame_valid;
                SEL_RX_LV: level_o = rx_sel.line_valid;
                default: level_o = rx_sel.remote_gpio[ctl_i.pin3_signal_select[1:0]];
            endcase
        end
        else if (ctl_i.pin3_source_select == SRC_STATUS)
        begin
            case (ctl_i.pin3_signal_select)
                SEL_ST_SWLEVEL: level_o = ctl_i.pin3_software_level;
                SEL_ST_LOCK_OR: level_o = |(lock_vec_o & rx_en_i);
                SEL_ST_PASS_AND, SEL_ST_PASS_AND_ALT:
                    level_o = (|rx_en_i) & (&(pass_vec_o | ~rx_en_i));
                SEL_ST_FSYNC: level_o = frame_sync_pulse_i;
                default: level_o = 1'b0;
            endcase
        end
        else if (gom_src_is_tx(ctl_i.pin3_source_select))
        begin
            case (ctl_i.pin3_signal_select)
                SEL_TX_PASS_AND: level_o = (|tx_mask) & (&(pass_vec_o | ~tx_mask));
                SEL_TX_PASS_OR: level_o = |(pass_vec_o & tx_mask);
                SEL_TX_FV: level_o = tx_sel.frame_valid;
                SEL_TX_LV: level_o = tx_sel.line_valid;
                SEL_TX_SYNCED: level_o = tx_sel.synced;
                SEL_TX_IRQ: level_o = tx_sel.irq;
                default: level_o = 1'b0;
            endcase
        end
    end

endmodule

// *** design/gom_pin3_output.sv ***
// Summary of operation
// - The source field in bits 4:2 picks receive port 0-3, device status, reserved 101, or TX 0/1.
// - With a receive port as source, select codes 000-011 give its remote GPIO 0-3.
// - With a receive port as source, select 100 gives its lock and 101 its pass indication.
// - With a receive port as source, select 110 gives its frame valid and 111 its line valid.
// - With device status as source, select 000 gives the software level bit of this register.
// - With device status as source, select 001 gives the OR of lock over enabled receive ports.
// - With device status as source, selects 010 and 011 give the AND of pass over enabled ports.
// - With device status as source, select 100 gives frame sync and 101-111 are reserved.
// - With a TX port as source, select 000 gives AND and 001 the OR of its chosen ports' pass.
// - With a TX port as source, select 010 gives its frame valid and 011 its line valid.
// - With a TX port as source, select 100 gives synchronized, 101 its interrupt, 110-111 reserved.
// - Bit 1 holds a software level used as the pin value when the register value is chosen.
// - The pin driver is enabled only while bit 0 is one, whatever source and select say.
// - The 8-bit control register sits at index 0x13 and resets to 0x00.
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module gom_pin3_output
    import gom_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    output logic [DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire gom_rx_s [RX_PORTS-1:0] rx_status_i,
    input wire logic [RX_PORTS-1:0] rx_enable_i,
    input wire gom_tx_s [TX_PORTS-1:0] tx_status_i,
    input wire logic frame_sync_pulse_i,
    output logic pin3_out_o,
    output logic pin3_oe_o
);

    gom_ctl_s pin3_output_control;
    gom_bus_e bus_state;
    gom_rx_s [RX_PORTS-1:0] rx_sync;
    gom_status_s status_word;
    logic [RX_PORTS-1:0] lock_vec;
    logic [RX_PORTS-1:0] pass_vec;
    logic mux_level;
    logic bus_req;
    logic hit_ctl;
    logic hit_status;
    logic [DATA_W-1:0] next_read_data;

    // Receive-port signals are recovered from the links and are not on this clock.
    gom_sync #(
        .WIDTH($bits(rx_status_i))
    ) u_rx_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(rx_status_i),
        .sync_o(rx_sync)
    );

    gom_level_mux u_mux (
        .ctl_i(pin3_output_control),
        .rx_i(rx_sync),
        .rx_en_i(rx_enable_i),
        .tx_i(tx_status_i),
        .frame_sync_pulse_i(frame_sync_pulse_i),
        .lock_vec_o(lock_vec),
        .pass_vec_o(pass_vec),
        .level_o(mux_level)
    );

    assign bus_req = wb_cyc_i && wb_stb_i && (bus_state == GOM_IDLE);

    always_comb
    begin
        hit_ctl = 1'b0;
        hit_status = 1'b0;
        if (wb_adr_i[ADR_W-1:WORD_LSB] == CTL_WORD)
        begin
            hit_ctl = 1'b1;
        end
        else if (wb_adr_i[ADR_W-1:WORD_LSB] == STATUS_WORD)
        begin
            hit_status = 1'b1;
        end
    end

    assign status_word = '{
        pass_vec: pass_vec,
        lock_vec: lock_vec,
        mux_level: mux_level,
        pin_enabled: pin3_oe_o,
        pin_level: pin3_out_o
    };

    // Unmapped addresses are acknowledged, read as zero and ignore writes.
    always_comb
    begin
        next_read_data = DATA_ZERO;
        if (hit_ctl)
        begin
            next_read_data = {{(DATA_W - $bits(gom_ctl_s)){1'b0}}, pin3_output_control};
        end
        else if (hit_status)
        begin
            next_read_data = {{(DATA_W - $bits(gom_status_s)){1'b0}}, status_word};
        end
    end

    // Every access is answered one cycle after it is seen; ack lasts one cycle.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bus_state <= GOM_IDLE;
            wb_ack_o <= 1'b0;
            wb_dat_o <= DATA_ZERO;
        end
        else
        begin
            case (bus_state)
                GOM_IDLE:
                begin
                    if (bus_req)
                    begin
                        bus_state <= GOM_ACK;
                        wb_ack_o <= 1'b1;
                        wb_dat_o <= wb_we_i ? DATA_ZERO : next_read_data;
                    end
                end
                GOM_ACK:
                begin
                    bus_state <= GOM_IDLE;
                    wb_ack_o <= 1'b0;
                end
                default:
                begin
                    bus_state <= GOM_IDLE;
                    wb_ack_o <= 1'b0;
                end
            endcase
        end
    end

    // Only byte lane 0 carries the control bits.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin3_output_control <= CTL_RESET;
        end
        else if (bus_req && wb_we_i && hit_ctl && wb_sel_i[0])
        begin
            pin3_output_control <= wb_dat_i[$bits(gom_ctl_s)-1:0];
        end
    end

    // A disabled pin is not driven and its output value is held low.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin3_out_o <= 1'b0;
            pin3_oe_o <= 1'b0;
        end
        else
        begin
            pin3_oe_o <= pin3_output_control.pin3_drive_enable;
            pin3_out_o <= pin3_output_control.pin3_drive_enable && mux_level;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking

    default disable iff (rst_i);

    logic [2:0] src;
    logic [2:0] sel;
    logic en;

    assign src = pin3_output_control.pin3_source_select;
    assign sel = pin3_output_control.pin3_signal_select;
    assign en = pin3_output_control.pin3_drive_enable;

    chk_reset_value: assert property (
        @(posedge clk_i) disable iff (1'b0)
        rst_i |=> (pin3_output_control == CTL_RESET) && !pin3_oe_o && !pin3_out_o)
        else $error("control register or pin not cleared by reset");

    chk_drive_off: assert property (
        !en |=> !pin3_oe_o && !pin3_out_o)
        else $error("pin driven while drive enable is low");

    chk_drive_on: assert property (
        en ##1 en |-> pin3_oe_o)
        else $error("pin driver off while drive enable is high");

    chk_rx_gpio: assert property (
        en && gom_src_is_rx(src) && (sel <= SEL_RX_GPIO_LAST)
        |=> pin3_out_o == $past(rx_sync[src[1:0]].remote_gpio[sel[1:0]]))
        else $error("receive port remote GPIO not routed to pin");

    chk_rx_lock_pass: assert property (
        en && gom_src_is_rx(src) && ((sel == SEL_RX_LOCK) || (sel == SEL_RX_PASS))
        |=> pin3_out_o == $past(sel == SEL_RX_LOCK ? rx_sync[src[1:0]].lock
                                                   : rx_sync[src[1:0]].pass))
        else $error("receive port lock or pass not routed to pin");

    chk_rx_video: assert property (
        en && gom_src_is_rx(src) && ((sel == SEL_RX_FV) || (sel == SEL_RX_LV))
        |=> pin3_out_o == $past(sel == SEL_RX_FV ? rx_sync[src[1:0]].frame_valid
                                                 : rx_sync[src[1:0]].line_valid))
        else $error("receive port frame or line valid not routed to pin");

    chk_sw_level: assert property (
        en && (src == SRC_STATUS) && (sel == SEL_ST_SWLEVEL)
        |=> pin3_out_o == $past(pin3_output_control.pin3_software_level))
        else $error("software level not driven on pin");

    chk_write_level: assert property (
        bus_req && wb_we_i && hit_ctl && wb_sel_i[0]
        |=> pin3_output_control.pin3_software_level == $past(wb_dat_i[1]))
        else $error("software level bit not stored by write");

    chk_status_lock_or: assert property (
        en && (src == SRC_STATUS) && (sel == SEL_ST_LOCK_OR)
        |=> pin3_out_o == $past(|(lock_vec & rx_enable_i)))
        else $error("lock OR over enabled ports wrong");

    chk_status_pass_and: assert property (
        en && (src == SRC_STATUS) && ((sel == SEL_ST_PASS_AND) || (sel == SEL_ST_PASS_AND_ALT))
        |=> pin3_out_o == $past((|rx_enable_i) && ((pass_vec & rx_enable_i) == rx_enable_i)))
        else $error("pass AND over enabled ports wrong");

    chk_frame_sync: assert property (
        en && (src == SRC_STATUS) && (sel == SEL_ST_FSYNC)
        |=> pin3_out_o == $past(frame_sync_pulse_i))
        else $error("frame sync not routed to pin");

    chk_status_reserved: assert property (
        (src == SRC_STATUS) && (sel > SEL_ST_FSYNC) |=> !pin3_out_o)
        else $error("reserved status select drives pin high");

    chk_tx_pass: assert property (
        en && gom_src_is_tx(src) && (sel == SEL_TX_PASS_OR)
        |=> pin3_out_o == $past(|(pass_vec & tx_status_i[src[0]].rx_mask)))
        else $error("transmit port pass OR wrong");

    chk_tx_video: assert property (
        en && gom_src_is_tx(src) && (sel == SEL_TX_FV)
        |=> pin3_out_o == $past(tx_status_i[src[0]].frame_valid))
        else $error("transmit port frame valid not routed to pin");

    chk_tx_irq: assert property (
        en && gom_src_is_tx(src) && (sel == SEL_TX_IRQ)
        |=> pin3_out_o == $past(tx_status_i[src[0]].irq))
        else $error("transmit port interrupt not routed to pin");

    chk_reserved_src: assert property (
        (src == SRC_RESERVED) || (gom_src_is_tx(src) && (sel > SEL_TX_IRQ))
        |=> !pin3_out_o)
        else $error("reserved code drives pin high");

    chk_ack_pulse: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus acknowledge not a single cycle after request");

    chk_ack_idle: assert property (
        !(wb_cyc_i && wb_stb_i) && !wb_ack_o |=> !wb_ack_o)
        else $error("bus acknowledge without a request");

    chk_bus_onehot: assert property (
        $onehot(bus_state))
        else $error("bus state not one-hot");

    chk_tx_pass_and: assert property (
        en && gom_src_is_tx(src) && (sel == SEL_TX_PASS_AND)
        |=> pin3_out_o == $past((|tx_status_i[src[0]].rx_mask)
            && ((pass_vec & tx_status_i[src[0]].rx_mask) == tx_status_i[src[0]].rx_mask)))
        else $error("transmit port pass AND wrong");

    chk_tx_line: assert property (
        en && gom_src_is_tx(src) && (sel == SEL_TX_LV)
        |=> pin3_out_o == $past(tx_status_i[src[0]].line_valid))
        else $error("transmit port line valid not routed to pin");

    chk_tx_synced: assert property (
        en && gom_src_is_tx(src) && (sel == SEL_TX_SYNCED)
        |=> pin3_out_o == $past(tx_status_i[src[0]].synced))
        else $error("transmit port synchronized flag not routed to pin");

    chk_oe_follow: assert property (
        1'b1 |=> pin3_oe_o == $past(en))
        else $error("driver enable does not follow the control bit");

    chk_out_needs_oe: assert property (
        pin3_out_o |-> pin3_oe_o)
        else $error("pin level high while driver is off");

    chk_ctl_write: assert property (
        bus_req && wb_we_i && hit_ctl && wb_sel_i[0]
        |=> pin3_output_control == $past(wb_dat_i[$bits(gom_ctl_s)-1:0]))
        else $error("control byte not stored by write");

    chk_ctl_hold: assert property (
        !(bus_req && wb_we_i && hit_ctl && wb_sel_i[0])
        |=> $stable(pin3_output_control))
        else $error("control register changed without a write");

    chk_read_ctl: assert property (
        bus_req && !wb_we_i && hit_ctl
        |=> wb_dat_o == DATA_W'($past(pin3_output_control)))
        else $error("control register read back wrong");

    chk_read_unmapped: assert property (
        bus_req && !wb_we_i && !hit_ctl && !hit_status
        |=> wb_dat_o == DATA_ZERO)
        else $error("unmapped read not zero");

    chk_read_status: assert property (
        bus_req && !wb_we_i && hit_status
        |=> wb_dat_o == DATA_W'($past(status_word)))
        else $error("status word read back wrong");

    chk_write_dat_zero: assert property (
        bus_req && wb_we_i
        |=> wb_dat_o == DATA_ZERO)
        else $error("read data not cleared by a write");

    chk_dat_hold: assert property (
        !bus_req |=> $stable(wb_dat_o))
        else $error("read data changed without a request");

    chk_rx_sync_delay: assert property (
        1'b1 |-> ##2 rx_sync == $past(rx_status_i, 2))
        else $error("receive status not delayed by two flip-flops");

endmodule

// *** design/gom_pkg.sv ***
package gom_pkg;

    localparam int RX_PORTS = 4;
    localparam int TX_PORTS = 2;
    localparam int REMOTE_GPIOS = 4;
    localparam int DATA_W = 32;
    localparam int ADR_W = 8;
    localparam int WORD_LSB = 2;

    // Register word indices; the byte address is four times the index.
    localparam logic [5:0] CTL_WORD = 6'h13;
    localparam logic [5:0] STATUS_WORD = 6'h20;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    // Source field codes.
    localparam logic [2:0] SRC_STATUS = 3'h4;
    localparam logic [2:0] SRC_RESERVED = 3'h5;
    localparam logic [2:0] SRC_TX0 = 3'h6;
    localparam logic [2:0] SRC_TX1 = 3'h7;

    // Select codes when a receive port is the source.
    localparam logic [2:0] SEL_RX_GPIO_LAST = 3'h3;
    localparam logic [2:0] SEL_RX_LOCK = 3'h4;
    localparam logic [2:0] SEL_RX_PASS = 3'h5;
    localparam logic [2:0] SEL_RX_FV = 3'h6;
    localparam logic [2:0] SEL_RX_LV = 3'h7;

    // Select codes when device status is the source.
    localparam logic [2:0] SEL_ST_SWLEVEL = 3'h0;
    localparam logic [2:0] SEL_ST_LOCK_OR = 3'h1;
    localparam logic [2:0] SEL_ST_PASS_AND = 3'h2;
    localparam logic [2:0] SEL_ST_PASS_AND_ALT = 3'h3;
    localparam logic [2:0] SEL_ST_FSYNC = 3'h4;

    // Select codes when a transmit port is the source.
    localparam logic [2:0] SEL_TX_PASS_AND = 3'h0;
    localparam logic [2:0] SEL_TX_PASS_OR = 3'h1;
    localparam logic [2:0] SEL_TX_FV = 3'h2;
    localparam logic [2:0] SEL_TX_LV = 3'h3;
    localparam logic [2:0] SEL_TX_SYNCED = 3'h4;
    localparam logic [2:0] SEL_TX_IRQ = 3'h5;

    typedef struct packed {
        logic [2:0] pin3_signal_select;
        logic [2:0] pin3_source_select;
        logic pin3_software_level;
        logic pin3_drive_enable;
    } gom_ctl_s;

    typedef struct packed {
        logic [3:0] remote_gpio;
        logic lock;
        logic pass;
        logic frame_valid;
        logic line_valid;
    } gom_rx_s;

    typedef struct packed {
        logic [3:0] rx_mask;
        logic frame_valid;
        logic line_valid;
        logic synced;
        logic irq;
    } gom_tx_s;

    typedef struct packed {
        logic [3:0] pass_vec;
        logic [3:0] lock_vec;
        logic mux_level;
        logic pin_enabled;
        logic pin_level;
    } gom_status_s;

    typedef enum logic [1:0] {
        GOM_IDLE = 2'b01,
        GOM_ACK = 2'b10
    } gom_bus_e;

    function automatic logic gom_src_is_rx(input logic [2:0] src);
        return src < SRC_STATUS;
    endfunction

    function automatic logic gom_src_is_tx(input logic [2:0] src);
        return (src == SRC_TX0) || (src == SRC_TX1);
    endfunction

endpackage

// *** design/gom_sync.sv ***
`timescale 1ns/10ps
module gom_sync
    import gom_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage_one;

    // The first stage feeds only the second one.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stage_one <= '0;
            sync_o <= '0;
        end
        else
        begin
            stage_one <= async_i;
            sync_o <= stage_one;
        end
    end

endmodule

// *** sim/gom_pin_sampler.sv ***
`timescale 1ns/10ps
module gom_pin_sampler
(
    input wire logic clk_i,
    input wire logic pin_out_i,
    input wire logic pin_oe_i,
    output logic pad_o,
    output logic sampled_o
);
    // The board pulls the pad down, so an undriven pin reads low.
    assign pad_o = pin_oe_i ? pin_out_i : 1'b0;

    always_ff @(posedge clk_i)
    begin
        sampled_o <= pad_o;
    end
endmodule

// *** sim/tb_gom_pin3_output.sv ***
`timescale 1ns/10ps
module tb_gom_pin3_output
    import gom_pkg::*;
();
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [3:0] sel = '0;
    logic [DATA_W-1:0] wdat = '0;
    logic [DATA_W-1:0] rdat;
    logic ack;
    gom_rx_s [RX_PORTS-1:0] rx_st = '0;
    logic [RX_PORTS-1:0] rx_en = '0;
    gom_tx_s [TX_PORTS-1:0] tx_st = '0;
    logic fsync = 1'b0;
    logic pin_out;
    logic pin_oe;
    logic pad;
    logic pad_q;
    logic [DATA_W-1:0] rd;
    logic [7:0] c;
    logic lvl;
    int err_total = 0;
    int compares = 0;
    integer seed = 12012;

    initial
    begin
        forever #25 clk = ~clk;
    end

    gom_pin3_output i_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .rx_status_i(rx_st), .rx_enable_i(rx_en), .tx_status_i(tx_st),
        .frame_sync_pulse_i(fsync), .pin3_out_o(pin_out), .pin3_oe_o(pin_oe));

    gom_pin_sampler i_board (.clk_i(clk), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
        .pad_o(pad), .sampled_o(pad_q));

    task automatic end_sim;
        $display("Summary: %0d compares, %0d errors", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input string name, input logic [DATA_W-1:0] exp,
        input logic [DATA_W-1:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One classic cycle; read data is taken at the edge where ack is seen.
    task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [3:0] s,
        input logic [DATA_W-1:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        rd = rdat;
        check("bus ack latency", 32'h2, 32'(n));
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    function automatic logic exp_level(input gom_ctl_s k, input gom_rx_s [RX_PORTS-1:0] r,
        input logic [RX_PORTS-1:0] e, input gom_tx_s [TX_PORTS-1:0] t, input logic f);
        logic [RX_PORTS-1:0] pv;
        logic [RX_PORTS-1:0] lk;
        gom_tx_s x;
        gom_rx_s y;
        logic [2:0] s;
        for (int i = 0; i < RX_PORTS; i++)
        begin
            pv[i] = r[i].pass;
            lk[i] = r[i].lock;
        end
        s = k.pin3_signal_select;
        x = t[k.pin3_source_select[0]];
        y = r[k.pin3_source_select[1:0]];
        if (!k.pin3_drive_enable)
            return 1'b0;
        case (k.pin3_source_select)
            3'h4:
                case (s)
                    3'h0: return k.pin3_software_level;
                    3'h1: return |(lk & e);
                    3'h2, 3'h3: return (e != 4'h0) && ((pv & e) == e);
                    3'h4: return f;
                    default: return 1'b0;
                endcase
            3'h5: return 1'b0;
            3'h6, 3'h7:
                case (s)
                    3'h0: return (x.rx_mask != 4'h0) && ((pv & x.rx_mask) == x.rx_mask);
                    3'h1: return |(pv & x.rx_mask);
                    3'h2: return x.frame_valid;
                    3'h3: return x.line_valid;
                    3'h4: return x.synced;
                    3'h5: return x.irq;
                    default: return 1'b0;
                endcase
            default:
                case (s)
                    3'h4: return y.lock;
                    3'h5: return y.pass;
                    3'h6: return y.frame_valid;
                    3'h7: return y.line_valid;
                    default: return y.remote_gpio[s[1:0]];
                endcase
        endcase
    endfunction

    function automatic logic [DATA_W-1:0] exp_status(input gom_ctl_s k, input logic l);
        logic [DATA_W-1:0] v;
        gom_ctl_s on;
        v = '0;
        on = k;
        on.pin3_drive_enable = 1'b1;
        for (int i = 0; i < RX_PORTS; i++)
        begin
            v[7 + i] = rx_st[i].pass;
            v[3 + i] = rx_st[i].lock;
        end
        v[2] = exp_level(on, rx_st, rx_en, tx_st, fsync);
        v[1] = k.pin3_drive_enable;
        v[0] = l;
        return v;
    endfunction

    initial
    begin
        #1000000;
        err_total++;
        $display("[ERR] watchdog expected finish seen hang");
        end_sim();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, 8'h4c, 4'hf, '0);
        check("ctl reset value", 32'h0, rd);
        check("oe after reset", 32'h0, {31'h0, pin_oe});
        bus(1'b0, 8'h44, 4'hf, '0);
        check("unmapped read", 32'h0, rd);
        bus(1'b1, 8'h4c, 4'he, 32'h0000_00ff);
        bus(1'b0, 8'h4c, 4'hf, '0);
        check("ctl with sel0 low", 32'h0, rd);
        for (int i = 0; i < 400; i++)
        begin
            // All codes with the driver on first, then random settings.
            c = (i < 128) ? {i[6:0], 1'b1} : 8'($random(seed));
            rx_st <= 32'($random(seed));
            rx_en <= 4'($random(seed));
            tx_st <= 16'($random(seed));
            fsync <= 1'($random(seed));
            bus(1'b1, 8'h4c, 4'h1, {24'h0, c});
            bus(1'b0, 8'h4c, 4'hf, '0);
            check("ctl readback", {24'h0, c}, rd);
            repeat (4) @(posedge clk);
            lvl = exp_level(gom_ctl_s'(c), rx_st, rx_en, tx_st, fsync);
            check("pin level", {31'h0, lvl}, {31'h0, pin_out});
            check("pin enable", {31'h0, c[0]}, {31'h0, pin_oe});
            check("board pad", {31'h0, lvl}, {31'h0, pad_q});
            bus(1'b0, 8'h80, 4'hf, '0);
            check("status word", exp_status(gom_ctl_s'(c), lvl), rd);
        end
        // A second reset in mid-run must clear whatever the loop left behind.
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, 8'h4c, 4'hf, '0);
        check("ctl after second reset", 32'h0, rd);
        check("pin after second reset", 32'h0, {30'h0, pin_oe, pin_out});
        end_sim();
    end
endmodule
